// ==== usb_test_ctrl.sv ====
// endpoint selector, test mode control, forced role and speed,
// loopback request, compliance pattern drive and max packet sizes.
// assumes a one-cycle register port and an async-read ep0 tx fifo.
`timescale 1ns/1ps
`include "usb_test_defines.svh"

module usb_test_ctrl
   import usb_test_pkg::*;
#(
   parameter int AW     = 8,
   parameter int DW     = 16,
   parameter int SEL_W  = `EP_SEL_W,
   parameter int MAXP_W = `MAXPKT_W
)
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // register port
   input  wire logic [AW-1:0]     i_addr,
   input  wire logic [DW-1:0]     i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DW-1:0]     o_rdata,
   // role
   input  wire logic              i_session,
   input  wire logic              i_role_host,
   output logic                   o_host_mode,
   output logic                   o_forced_host,
   // speed
   input  wire logic              i_bus_reset,
   input  wire logic              i_hs_chirp_ok,
   output speed_t                 o_speed,
   // endpoint selection
   output logic      [SEL_W-1:0]  o_ep_sel,
   output logic      [MAXP_W-1:0] o_tx_maxpkt,
   // ep0 loopback
   output logic                   o_ep0_loopback,
   // compliance pattern
   input  wire logic [7:0]        i_fifo_rdata,
   input  wire logic              i_phy_ready,
   output logic      [5:0]        o_fifo_addr,
   output logic      [7:0]        o_tx_data,
   output logic                   o_tx_valid,
   output logic                   o_tx_last,
   output logic                   o_drive_j,
   output logic                   o_drive_k,
   // in token handling
   input  wire logic              i_in_token,
   output logic                   o_nak_all_in,
   output logic                   o_send_nak
);

   // =======================================================
   // decode
   logic                  wr_sel;
   logic                  wr_test;
   logic                  wr_txp;
   logic                  wr_rxp;
   logic [SEL_W-1:0]      ep_sel_r;
   logic [7:0]            test_ctrl_r;
   logic                  forced_r;
   logic [MAXP_W-1:0]     tx_word;
   logic [MAXP_W-1:0]     rx_word;
   logic [DW-1:0]         rdata_nxt;
   pkt_state_t            pk_state_r;
   logic [`PKT_IDX_W-1:0] idx_r;

   assign wr_sel  = i_wr && (i_addr == `OFS_EP_SEL);
   assign wr_test = i_wr && (i_addr == `OFS_TEST_CTRL);
   assign wr_txp  = i_wr && (i_addr == `OFS_TX_MAXPKT);
   assign wr_rxp  = i_wr && (i_addr == `OFS_RX_MAXPKT);

   // =======================================================
   // endpoint selector
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         ep_sel_r <= `EP_SEL_RST;
      else if (wr_sel)
         ep_sel_r <= i_wdata[SEL_W-1:0];
   end

   // =======================================================
   // per-endpoint max packet banks
   ep_maxpkt_bank #(
      .SEL_W   (SEL_W),
      .W       (MAXP_W)
   ) u_tx_bank (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_sel   (ep_sel_r),
      .i_we    (wr_txp),
      .i_wdata (i_wdata[MAXP_W-1:0]),
      .o_rdata (tx_word)
   );

   ep_maxpkt_bank #(
      .SEL_W   (SEL_W),
      .W       (MAXP_W)
   ) u_rx_bank (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_sel   (ep_sel_r),
      .i_we    (wr_rxp),
      .i_wdata (i_wdata[MAXP_W-1:0]),
      .o_rdata (rx_word)
   );

   // =======================================================
   // test control; loopback bit is never stored
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         test_ctrl_r <= `TEST_CTRL_RST;
      else if (wr_test)
         test_ctrl_r <= i_wdata[7:0] & `TEST_CTRL_WMASK;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_ep0_loopback <= 1'b0;
      else
         o_ep0_loopback <= wr_test && i_wdata[`TC_LOOPBACK];
   end

   // =======================================================
   // forced host role, held until the session ends
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         forced_r <= 1'b0;
      else if (!i_session)
         forced_r <= 1'b0;
      else if (test_ctrl_r[`TC_HOST_OVR])
         forced_r <= 1'b1;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_host_mode   <= 1'b0;
         o_forced_host <= 1'b0;
      end
      else
      begin
         o_host_mode   <= forced_r || i_role_host;
         o_forced_host <= forced_r;
      end
   end

   // =======================================================
   // operating speed
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_speed <= SPD_FULL;
      else if (test_ctrl_r[`TC_SE0_NAK])
         o_speed <= SPD_HIGH;
      else if (forced_r)
      begin
         if (test_ctrl_r[`TC_FS_OVR])
            o_speed <= SPD_FULL;
         else if (test_ctrl_r[`TC_HS_OVR])
            o_speed <= SPD_HIGH;
         else
            o_speed <= SPD_FULL;
      end
      else if (i_bus_reset)
      begin
         if (test_ctrl_r[`TC_FS_OVR])
            o_speed <= SPD_FULL;
         else if (test_ctrl_r[`TC_HS_OVR])
            o_speed <= SPD_HIGH;
         else if (i_hs_chirp_ok)
            o_speed <= SPD_HIGH;
         else
            o_speed <= SPD_FULL;
      end
   end

   // =======================================================
   // j and k line states
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_drive_j <= 1'b0;
         o_drive_k <= 1'b0;
      end
      else
      begin
         o_drive_k <= test_ctrl_r[`TC_K_STATE];
         o_drive_j <= test_ctrl_r[`TC_J_STATE] &&
                      !test_ctrl_r[`TC_K_STATE];
      end
   end

   // =======================================================
   // nak every in token in se0 nak mode
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_nak_all_in <= 1'b0;
         o_send_nak   <= 1'b0;
      end
      else
      begin
         o_nak_all_in <= test_ctrl_r[`TC_SE0_NAK];
         o_send_nak   <= test_ctrl_r[`TC_SE0_NAK] && i_in_token;
      end
   end

   // =======================================================
   // repeating test packet from ep0 fifo
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pk_state_r <= PK_IDLE;
         idx_r      <= '0;
         o_tx_valid <= 1'b0;
         o_tx_last  <= 1'b0;
         o_tx_data  <= 8'h00;
      end
      else
      begin
         case (pk_state_r)
            PK_IDLE:
            begin
               idx_r      <= '0;
               o_tx_valid <= 1'b0;
               o_tx_last  <= 1'b0;
               if (test_ctrl_r[`TC_PACKET])
                  pk_state_r <= PK_SEND;
            end
            PK_SEND:
            begin
               if (!test_ctrl_r[`TC_PACKET])
               begin
                  pk_state_r <= PK_IDLE;
                  o_tx_valid <= 1'b0;
                  o_tx_last  <= 1'b0;
               end
               else if (!o_tx_valid || i_phy_ready)
               begin
                  o_tx_data  <= i_fifo_rdata;
                  o_tx_valid <= 1'b1;
                  o_tx_last  <= (idx_r == `PKT_LAST);
                  if (idx_r == `PKT_LAST)
                     idx_r <= '0;
                  else
                     idx_r <= idx_r + 1'b1;
               end
            end
            default:
               pk_state_r <= PK_IDLE;
         endcase
      end
   end

   assign o_fifo_addr = idx_r;

   // =======================================================
   // read port, data one cycle after the strobe
   always_comb
   begin
      rdata_nxt = '0;
      case (i_addr)
         `OFS_EP_SEL:
            rdata_nxt = {{(DW-SEL_W){1'b0}}, ep_sel_r};
         `OFS_TEST_CTRL:
            rdata_nxt = {8'h00, test_ctrl_r};
         `OFS_TX_MAXPKT:
            rdata_nxt = {{(DW-MAXP_W){1'b0}}, tx_word};
         `OFS_RX_MAXPKT:
            rdata_nxt = {{(DW-MAXP_W){1'b0}}, rx_word};
         `OFS_ROLE_STAT:
            rdata_nxt = {12'h000, (pk_state_r == PK_SEND), forced_r,
                         (o_speed == SPD_HIGH), o_host_mode};
         default:
            rdata_nxt = '0;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rdata     <= '0;
         o_ep_sel    <= `EP_SEL_RST;
         o_tx_maxpkt <= '0;
      end
      else
      begin
         o_rdata     <= i_rd ? rdata_nxt : '0;
         o_ep_sel    <= ep_sel_r;
         o_tx_maxpkt <= tx_word;
      end
   end

   // =======================================================
   // checks
   AST_SEL_READ:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == `OFS_EP_SEL) |=>
      (o_rdata == {12'h000, $past(ep_sel_r)}))
      else $error("selector read mismatch");

   AST_HOST_FORCE:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (test_ctrl_r[`TC_HOST_OVR] && i_session) ##1 i_session
      |=> o_host_mode)
      else $error("forced host role not entered");

   AST_HOST_HOLD:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (forced_r && i_session && !i_role_host)[*2] |=> o_host_mode)
      else $error("forced host role dropped in session");

   AST_REENTER:
   assert property (@(posedge i_clk) disable iff (i_rst)
      ($rose(i_session) && test_ctrl_r[`TC_HOST_OVR]) |=> forced_r)
      else $error("host role not re-entered");

   AST_LOOPBACK:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (wr_test && i_wdata[`TC_LOOPBACK]) |=>
      (o_ep0_loopback && !test_ctrl_r[`TC_LOOPBACK])
      ##1 (!o_ep0_loopback || $past(wr_test)))
      else $error("loopback pulse wrong");

   AST_SPEED_FS:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (i_bus_reset && test_ctrl_r[`TC_FS_OVR] && !forced_r &&
       !test_ctrl_r[`TC_SE0_NAK]) |=> (o_speed == SPD_FULL))
      else $error("full speed not settled");

   AST_SPEED_HS:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (i_bus_reset && test_ctrl_r[`TC_HS_OVR] && !forced_r &&
       !test_ctrl_r[`TC_FS_OVR]) |=> (o_speed == SPD_HIGH))
      else $error("high speed not settled");

   AST_PKT_WRAP:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (pk_state_r == PK_SEND && (!o_tx_valid || i_phy_ready) &&
       test_ctrl_r[`TC_PACKET] && idx_r == `PKT_LAST) |=>
      (o_tx_last && o_fifo_addr == 6'h00))
      else $error("packet did not wrap after 53 bytes");

   AST_K_DRIVE:
   assert property (@(posedge i_clk) disable iff (i_rst)
      test_ctrl_r[`TC_K_STATE] [*2] |-> (o_drive_k && !o_drive_j))
      else $error("k state not driven");

   AST_NAK:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (test_ctrl_r[`TC_SE0_NAK] && i_in_token) |=>
      (o_send_nak && o_speed == SPD_HIGH))
      else $error("in token not naked");

   AST_MAXP_READ:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == `OFS_TX_MAXPKT) |=>
      (o_rdata[15:11] == 5'h00 && o_rdata[10:0] == $past(tx_word)))
      else $error("max packet read wrong");

endmodule // usb_test_ctrl

// ==== usb_test_defines.svh ====
// offsets, field positions, reset values and counts for the test and
// endpoint select block.
// assumes a byte-addressed register port with 16-bit data.
`ifndef USB_TEST_DEFINES_SVH
`define USB_TEST_DEFINES_SVH

// ==========================================================
// register offsets
`define OFS_EP_SEL      8'h0E
`define OFS_TEST_CTRL   8'h0F
`define OFS_TX_MAXPKT   8'h10
`define OFS_RX_MAXPKT   8'h14
`define OFS_ROLE_STAT   8'h18

// ==========================================================
// test control field positions
`define TC_HOST_OVR     7
`define TC_LOOPBACK     6
`define TC_FS_OVR       5
`define TC_HS_OVR       4
`define TC_PACKET       3
`define TC_K_STATE      2
`define TC_J_STATE      1
`define TC_SE0_NAK      0

// ==========================================================
// widths and reset values
`define EP_SEL_W        4
`define MAXPKT_W        11
`define EP_SEL_RST      4'h0
`define TEST_CTRL_RST   8'h00
`define TEST_CTRL_WMASK 8'hBF

// ==========================================================
// compliance test packet
`define PKT_IDX_W       6
`define PKT_LEN         6'h35
`define PKT_LAST        6'h34

`endif

// ==== usb_test_pkg.sv ====
// types shared by the test and endpoint select block.
// assumes nothing of its surroundings.
package usb_test_pkg;

   // =======================================================
   // operating speed
   typedef enum logic [0:0] {
      SPD_FULL,
      SPD_HIGH
   } speed_t;

   // =======================================================
   // test packet sequencer
   typedef enum logic [0:0] {
      PK_IDLE,
      PK_SEND
   } pkt_state_t;

endpackage

// ==== ep_maxpkt_bank.sv ====
// one max packet size word per endpoint, indexed by the selector.
// assumes a write strobe already decoded for this bank.
`timescale 1ns/1ps

module ep_maxpkt_bank
#(
   parameter int SEL_W = 4,
   parameter int W     = 11
)
(
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // access
   input  wire logic [SEL_W-1:0] i_sel,
   input  wire logic             i_we,
   input  wire logic [W-1:0]     i_wdata,
   output logic      [W-1:0]     o_rdata
);

   localparam int NUM_EP = 1 << SEL_W;

   // =======================================================
   // storage
   logic [W-1:0] words_r [NUM_EP];

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int i = 0; i < NUM_EP; i++)
            words_r[i] <= '0;
      end
      else if (i_we)
      begin
         words_r[i_sel] <= i_wdata;
      end
   end

   assign o_rdata = words_r[i_sel];

endmodule // ep_maxpkt_bank

// ==== usb_far_side.sv ====
// far side model: ep0 fifo holding the test packet, and a phy
// that stalls one cycle in four. assumes async fifo reads by index.
`timescale 1ns/1ps

module usb_far_side
(
   // clock
   input  wire logic       i_clk,
   // fifo and phy
   input  wire logic [5:0] i_fifo_addr,
   output logic      [7:0] o_fifo_rdata,
   output logic            o_phy_ready
);
   logic [7:0] mem [0:63];
   logic [1:0] cnt_r = 2'h0;

   // ==========================================================
   // fifo loaded before any test mode starts
   initial
   begin
      for (int i = 0; i < 64; i++)
         mem[i] = 8'(i * 7 + 3);
   end
   assign o_fifo_rdata = mem[i_fifo_addr];

   // ==========================================================
   // phy acceptance with regular stalls
   always @(posedge i_clk)
      cnt_r <= cnt_r + 2'h1;
   assign o_phy_ready = (cnt_r != 2'h3);
endmodule // usb_far_side

// ==== usb_test_ctrl_tb_top.sv ====
// self-checking bench for the test mode and endpoint select block.
// assumes the far side model and the design files compiled first.
`timescale 1ns/1ps
`include "usb_test_defines.svh"

module usb_test_ctrl_tb_top;
   logic                 clk, rst, wr, rd, sess, role, brst, chirp, tok;
   logic [7:0]           addr, txd, fdata;
   logic [15:0]          wdata, rdata;
   logic                 host, forced, lpb, tx_v, tx_l, dj, dk, ready;
   logic                 nak_all, nak;
   logic [3:0]           ep_sel;
   logic [10:0]          maxp;
   logic [5:0]           faddr;
   usb_test_pkg::speed_t spd;
   int                   failures, comparisons;

   usb_test_ctrl dut (.i_clk(clk), .i_rst(rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_session(sess), .i_role_host(role), .o_host_mode(host),
      .o_forced_host(forced), .i_bus_reset(brst), .i_hs_chirp_ok(chirp),
      .o_speed(spd), .o_ep_sel(ep_sel), .o_tx_maxpkt(maxp),
      .o_ep0_loopback(lpb), .i_fifo_rdata(fdata), .i_phy_ready(ready),
      .o_fifo_addr(faddr), .o_tx_data(txd), .o_tx_valid(tx_v),
      .o_tx_last(tx_l), .o_drive_j(dj), .o_drive_k(dk),
      .i_in_token(tok), .o_nak_all_in(nak_all), .o_send_nak(nak));

   usb_far_side far (.i_clk(clk), .i_fifo_addr(faddr),
      .o_fifo_rdata(fdata), .o_phy_ready(ready));

   // ==========================================================
   // bus and compare helpers
   task automatic chk(input string nm, input logic [15:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(nm, e, rdata);
   endtask

   task automatic bus_reset();
      @(posedge clk);
      brst <= 1'b1;
      @(posedge clk);
      brst <= 1'b0;
      cyc(2);
   endtask

   task automatic test_done();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_select();
      rchk("sel_rst", `OFS_EP_SEL, 16'h0000);
      rchk("test_rst", `OFS_TEST_CTRL, 16'h0000);
      rchk("max_rst", `OFS_TX_MAXPKT, 16'h0000);
      reg_wr(`OFS_EP_SEL, 16'h00FF);
      rchk("sel", `OFS_EP_SEL, 16'h000F);
      chk("ep_sel", 16'h000F, {12'h0, ep_sel});
      reg_wr(`OFS_EP_SEL, 16'h0003);
      reg_wr(`OFS_TX_MAXPKT, 16'hFC00);
      reg_wr(`OFS_EP_SEL, 16'h0005);
      reg_wr(`OFS_TX_MAXPKT, 16'h0123);
      rchk("max5", `OFS_TX_MAXPKT, 16'h0123);
      chk("maxp", 16'h0123, {5'h0, maxp});
      reg_wr(`OFS_EP_SEL, 16'h0003);
      rchk("max3", `OFS_TX_MAXPKT, 16'h0400);
      reg_wr(`OFS_RX_MAXPKT, 16'h07FF);
      rchk("rx3", `OFS_RX_MAXPKT, 16'h07FF);
      rchk("tx3", `OFS_TX_MAXPKT, 16'h0400);
      rchk("unmapped", 8'h20, 16'h0000);
   endtask

   task automatic t_speed();
      reg_wr(`OFS_TEST_CTRL, 16'h0010);
      chirp <= 1'b0;
      bus_reset();
      chk("spd_hs", 16'h0001, {15'h0, spd});
      reg_wr(`OFS_TEST_CTRL, 16'h0020);
      chirp <= 1'b1;
      bus_reset();
      chk("spd_fs", 16'h0000, {15'h0, spd});
      reg_wr(`OFS_TEST_CTRL, 16'h0000);
      bus_reset();
      chk("spd_chirp", 16'h0001, {15'h0, spd});
      chirp <= 1'b0;
      bus_reset();
      chk("spd_nochirp", 16'h0000, {15'h0, spd});
   endtask

   task automatic t_host();
      reg_wr(`OFS_TEST_CTRL, 16'h0080);
      sess <= 1'b1;
      cyc(3);
      chk("forced", 16'h0001, {15'h0, forced});
      chk("host", 16'h0001, {15'h0, host});
      rchk("status", `OFS_ROLE_STAT, 16'h0005);
      reg_wr(`OFS_TEST_CTRL, 16'h0090);
      cyc(2);
      chk("spd_fh", 16'h0001, {15'h0, spd});
      reg_wr(`OFS_TEST_CTRL, 16'h00A0);
      cyc(2);
      chk("spd_ff", 16'h0000, {15'h0, spd});
      reg_wr(`OFS_TEST_CTRL, 16'h0000);
      cyc(2);
      chk("forced_hold", 16'h0001, {15'h0, forced});
      sess <= 1'b0;
      cyc(3);
      chk("host_end", 16'h0000, {14'h0, forced, host});
      reg_wr(`OFS_TEST_CTRL, 16'h0080);
      cyc(3);
      chk("no_sess", 16'h0000, {15'h0, forced});
      sess <= 1'b1;
      cyc(3);
      chk("reenter", 16'h0003, {14'h0, forced, host});
      sess <= 1'b0;
      reg_wr(`OFS_TEST_CTRL, 16'h0000);
      role <= 1'b1;
      cyc(3);
      chk("normal", 16'h0001, {14'h0, forced, host});
      role <= 1'b0;
   endtask

   task automatic t_modes();
      reg_wr(`OFS_TEST_CTRL, 16'h0040);
      #1;
      chk("loop", 16'h0001, {15'h0, lpb});
      cyc(1);
      chk("loop_end", 16'h0000, {15'h0, lpb});
      rchk("loop_rd", `OFS_TEST_CTRL, 16'h0000);
      reg_wr(`OFS_TEST_CTRL, 16'h0004);
      cyc(2);
      chk("k", 16'h0002, {14'h0, dk, dj});
      reg_wr(`OFS_TEST_CTRL, 16'h0002);
      cyc(2);
      chk("j", 16'h0001, {14'h0, dk, dj});
      reg_wr(`OFS_TEST_CTRL, 16'h0001);
      cyc(2);
      chk("se0nak", 16'h0003, {14'h0, nak_all, spd});
      @(posedge clk);
      tok <= 1'b1;
      @(posedge clk);
      tok <= 1'b0;
      #1;
      chk("nak", 16'h0001, {15'h0, nak});
      cyc(1);
      chk("nak_end", 16'h0000, {15'h0, nak});
      reg_wr(`OFS_TEST_CTRL, 16'h0000);
   endtask

   task automatic t_packet();
      int n;
      int k;
      n = 0;
      reg_wr(`OFS_TEST_CTRL, 16'h0008);
      for (int c = 0; c < 1000 && n < 106; c++)
      begin
         @(negedge clk);
         if (tx_v === 1'b1 && ready)
         begin
            k = n % 53;
            chk("tx_data", {8'h0, 8'(k * 7 + 3)}, {8'h0, txd});
            chk("tx_last", {15'h0, k == 52}, {15'h0, tx_l});
            chk("fifo_addr", 16'((k + 1) % 53), {10'h0, faddr});
            n++;
         end
      end
      chk("tx_count", 16'd106, 16'(n));
      reg_wr(`OFS_TEST_CTRL, 16'h0000);
      cyc(3);
      chk("tx_stop", 16'h0000, {15'h0, tx_v});
   endtask

   // ==========================================================
   // clock, main sequence, watchdog
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      {rst, wr, rd, sess, role, brst, chirp, tok} = 8'h80;
      addr = 8'h00;
      wdata = 16'h0000;
      failures = 0;
      comparisons = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_select();
      t_speed();
      t_host();
      t_modes();
      t_packet();
      test_done();
   end

   initial
   begin
      #100000;
      failures++;
      test_done();
   end
endmodule // usb_test_ctrl_tb_top
